// File: design/harvest_map.svh
/*
 Register offsets, reset values, the pulse count maximum and measurement period codes and lengths of the harvest
 measurement and sleep register bank. Assumes plain textual inclusion.
*/
`ifndef HARVEST_MAP_SVH
`define HARVEST_MAP_SVH

`define OCV_RESULT_ADDR 8'h09
`define PULSE_HIGH_ADDR 8'h0A
`define PULSE_LOW_ADDR 8'h0B
`define SLEEP_THR_ADDR 8'h0C
`define OCV_RESULT_RESET 8'h1D
`define SLEEP_THR_RESET 8'h00
`define PULSE_COUNT_MAX 16'hFFFF
`define PERIOD_OFF 2'h3
`define PERIOD_64 32'd64
`define PERIOD_128 32'd128
`define PERIOD_256 32'd256

`endif

// File: design/harvest_pkg.sv
/*
 Types of the harvest measurement and sleep register bank.
 Assumes harvest_map.svh is available on the include path.
*/
package harvest_pkg;
   typedef enum logic [1:0] {
      MODE_AWAKE = 2'b00,
      MODE_VOLTS_SLEEP = 2'b01,
      MODE_COUNT_SLEEP = 2'b11
   } sleep_mode_t;
endpackage : harvest_pkg

// File: design/pulse_counter.sv
/*
 Saturating WIDTH-bit counter of boost switching pulses (WIDTH is 16 by default).
 Assumes the pulse input is already synchronised to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "harvest_map.svh"
module pulse_counter #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic pulse,
   input wire logic enable,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (pulse && enable && count_reg != {WIDTH{1'b1}}) begin
         count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count_reg <= '0;
      end else if (clk_en) begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;

   saturate_hold_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && count_reg == {WIDTH{1'b1}} |=> count_reg == {WIDTH{1'b1}})
      else $error("pulse count wrapped");
endmodule : pulse_counter
`default_nettype wire

// File: design/harvest_measure_sleep_regs.sv
/*
 Measurement result, pulse count and count-based sleep registers.
 Assumes a register-level access port from the serial interface logic,
 a measurement engine that reports results, and raw pins for the
 inductor switch pulse and the wake comparator.
*/
`timescale 1ns/1ps
`default_nettype none
`include "harvest_map.svh"
module harvest_measure_sleep_regs
   import harvest_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic force_measure,
   input wire logic [1:0] measure_period,
   input wire logic measure_time_tick,
   input wire logic meas_done,
   input wire logic [7:0] meas_result,
   input wire logic inductor_switch_node,
   input wire logic wake_above,
   output logic meas_start,
   output logic force_pending,
   output logic count_valid,
   output logic boost_halt,
   output logic sleep_active
);
   sleep_mode_t mode_reg, mode_next;
   logic [7:0] ocv_reg, ocv_next;
   logic [7:0] thr_reg, thr_next;
   logic [7:0] rdata_reg, rdata_next;
   logic pend_reg, pend_next;
   logic start_reg, start_next;
   logic [8:0] tick_reg, tick_next;
   logic [2:0] lx_sync_reg;
   logic [1:0] wake_sync_reg;
   logic lx_pulse;
   logic [COUNT_WIDTH-1:0] count;
   logic [15:0] count_wide;
   logic [8:0] period_len;
   logic new_meas;
   logic ocv_wr;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         lx_sync_reg <= 3'h0;
         wake_sync_reg <= 2'h0;
      end else if (clk_en) begin
         lx_sync_reg <= {lx_sync_reg[1:0], inductor_switch_node};
         wake_sync_reg <= {wake_sync_reg[0], wake_above};
      end
   end

   assign lx_pulse = lx_sync_reg[1] & ~lx_sync_reg[2];

   // ------------------------------------------------------------
   // Switching pulse counter
   // ------------------------------------------------------------
   pulse_counter #(
      .WIDTH(COUNT_WIDTH)
   ) u_count (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .pulse(lx_pulse),
      .enable(mode_reg == MODE_AWAKE),
      .count(count)
   );

   assign count_valid = wake_sync_reg[1];
   // 16-bit view of the count, zero-extended from narrower widths and truncated from wider ones
   assign count_wide = 16'(count);

   // ------------------------------------------------------------
   // Measurement scheduling
   // ------------------------------------------------------------
   function automatic logic [8:0] period_of(input logic [1:0] code);
      unique case (code)
         2'h0: period_of = 9'(`PERIOD_64);
         2'h1: period_of = 9'(`PERIOD_128);
         2'h2: period_of = 9'(`PERIOD_256);
         default: period_of = 9'h000;
      endcase
   endfunction : period_of

   assign period_len = period_of(measure_period);
   assign new_meas = meas_done;
   assign ocv_wr = reg_wr && reg_addr == `OCV_RESULT_ADDR;

   always_comb begin
      tick_next = tick_reg;
      pend_next = pend_reg;
      start_next = 1'b0;
      if (measure_period != `PERIOD_OFF && measure_time_tick) begin
         if (tick_reg + 9'h001 >= period_len) begin
            tick_next = 9'h000;
            start_next = 1'b1;
         end else begin
            tick_next = tick_reg + 9'h001;
         end
      end
      if (force_measure && !pend_reg) begin
         pend_next = 1'b1;
         start_next = 1'b1;
      end else if (meas_done) begin
         pend_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         tick_reg <= 9'h000;
         pend_reg <= 1'b0;
         start_reg <= 1'b0;
      end else if (clk_en) begin
         tick_reg <= tick_next;
         pend_reg <= pend_next;
         start_reg <= start_next;
      end
   end

   assign meas_start = start_reg;
   assign force_pending = pend_reg;

   // ------------------------------------------------------------
   // Registers and sleep control
   // ------------------------------------------------------------
   always_comb begin
      ocv_next = ocv_reg;
      thr_next = thr_reg;
      mode_next = mode_reg;
      if (new_meas) begin
         ocv_next = meas_result;
      end else if (ocv_wr) begin
         ocv_next = reg_wdata;
      end
      if (reg_wr && reg_addr == `SLEEP_THR_ADDR) begin
         thr_next = reg_wdata;
      end
      if (new_meas || ocv_wr) begin
         if (ocv_next < `OCV_RESULT_RESET) begin
            mode_next = MODE_VOLTS_SLEEP;
         end else begin
            mode_next = MODE_AWAKE;
         end
      end else if (mode_reg == MODE_AWAKE && thr_reg != 8'h00 &&
                   count < {{(COUNT_WIDTH-8){1'b0}}, thr_reg}) begin
         mode_next = MODE_COUNT_SLEEP;
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         unique case (reg_addr)
            `OCV_RESULT_ADDR: rdata_next = ocv_reg;
            `PULSE_HIGH_ADDR: rdata_next = count_wide[15:8];
            `PULSE_LOW_ADDR: rdata_next = count_wide[7:0];
            `SLEEP_THR_ADDR: rdata_next = thr_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ocv_reg <= `OCV_RESULT_RESET;
         thr_reg <= `SLEEP_THR_RESET;
         mode_reg <= MODE_AWAKE;
         rdata_reg <= 8'h00;
      end else if (clk_en) begin
         ocv_reg <= ocv_next;
         thr_reg <= thr_next;
         mode_reg <= mode_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign sleep_active = mode_reg != MODE_AWAKE;
   assign boost_halt = sleep_active;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   low_write_sleep_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && ocv_wr && !new_meas && reg_wdata < `OCV_RESULT_RESET
      |=> boost_halt && mode_reg == MODE_VOLTS_SLEEP)
      else $error("low write did not halt boost");
   high_write_wake_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && ocv_wr && !new_meas && reg_wdata >= `OCV_RESULT_RESET
      |=> mode_reg != MODE_VOLTS_SLEEP)
      else $error("high write did not leave sleep");
   write_stores_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && ocv_wr && !new_meas |=> ocv_reg == $past(reg_wdata))
      else $error("write not stored");
   meas_stores_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && new_meas |=> ocv_reg == $past(meas_result))
      else $error("measurement not stored");
   read_quiet_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && reg_rd && !reg_wr && !new_meas && !force_measure
      |=> $stable(ocv_reg) && !(pend_reg && !$past(pend_reg)))
      else $error("read disturbed result");
   sleep_frozen_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && sleep_active |=> $stable(count))
      else $error("count moved in sleep");
   zero_thr_off_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && thr_reg == 8'h00 && mode_reg == MODE_AWAKE
      |=> mode_reg != MODE_COUNT_SLEEP)
      else $error("zero threshold slept");
   count_sleep_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && mode_reg == MODE_AWAKE && !new_meas && !ocv_wr &&
      thr_reg != 8'h00 && count_wide < {8'h00, thr_reg}
      |=> mode_reg == MODE_COUNT_SLEEP)
      else $error("low count did not sleep");
   force_start_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && force_measure && !pend_reg |=> meas_start ##1 !meas_start
      || !clk_en)
      else $error("force did not start once");
   high_byte_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && reg_rd && reg_addr == `PULSE_HIGH_ADDR
      |=> reg_rdata == $past(count_wide[15:8]))
      else $error("high byte wrong");
   low_byte_a: assert property (
      @(posedge core_clk) disable iff (reset)
      clk_en && reg_rd && reg_addr == `PULSE_LOW_ADDR
      |=> reg_rdata == $past(count_wide[7:0]))
      else $error("low byte wrong");

   volts_sleep_c: cover property (@(posedge core_clk)
      mode_reg == MODE_VOLTS_SLEEP);
   count_sleep_c: cover property (@(posedge core_clk)
      mode_reg == MODE_COUNT_SLEEP ##1 mode_reg == MODE_AWAKE);
   period_start_c: cover property (@(posedge core_clk)
      meas_start && !pend_reg);
endmodule : harvest_measure_sleep_regs
`default_nettype wire

// File: verification/meas_engine_model.sv
/*
 Stand-in for the measurement engine on the far side of the bank.
 Assumes it shares core_clk; answers lag+1 cycles after the latest start.
*/
`timescale 1ns/1ps
`default_nettype none
module meas_engine_model (
   input wire logic core_clk,
   input wire logic meas_start,
   input wire logic [7:0] answer,
   input wire logic [3:0] lag,
   output logic meas_done,
   output logic [7:0] meas_result
);
   int wait_left = -1;
   logic [7:0] last = 8'h00;
   always @(posedge core_clk) begin
      meas_done <= 1'b0;
      // Outside a done pulse the result lines show no stale code
      meas_result <= ~last;
      if (meas_start === 1'b1) begin
         wait_left <= int'(lag);
      end else if (wait_left > 0) begin
         wait_left <= wait_left - 1;
      end else if (wait_left == 0) begin
         wait_left <= -1;
         meas_done <= 1'b1;
         meas_result <= answer;
         last <= answer;
      end
   end
endmodule : meas_engine_model
`default_nettype wire

// File: verification/testbench.sv
/*
 Self-checking bench for the harvest register bank.
 Assumes the design files and the engine model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int CW = 10;
   localparam logic [15:0] CMAX = 16'((1 << CW) - 1);
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic force_measure = 1'b0;
   logic measure_time_tick = 1'b0;
   logic node = 1'b0;
   logic wake_above = 1'b0;
   logic [1:0] measure_period = 2'h3;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] answer = 8'h40;
   logic [3:0] lag = 4'h2;
   logic [7:0] reg_rdata, meas_result;
   logic meas_start, force_pending, count_valid, boost_halt;
   logic sleep_active, meas_done;
   int err_count = 0;
   int cmp_count = 0;
   int starts = 0;
   int s0;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) if (meas_start === 1'b1) starts <= starts + 1;
   harvest_measure_sleep_regs #(.COUNT_WIDTH(CW)) i_harvest_measure_sleep_regs (
      .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .force_measure(force_measure),
      .measure_period(measure_period),
      .measure_time_tick(measure_time_tick), .meas_done(meas_done),
      .meas_result(meas_result), .inductor_switch_node(node),
      .wake_above(wake_above), .meas_start(meas_start),
      .force_pending(force_pending), .count_valid(count_valid),
      .boost_halt(boost_halt), .sleep_active(sleep_active));
   meas_engine_model i_meas_engine_model (.core_clk(core_clk),
      .meas_start(meas_start), .answer(answer), .lag(lag),
      .meas_done(meas_done), .meas_result(meas_result));
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      // Read data stands from the strobe edge until the next read
      @(posedge core_clk);
      chk(16'(reg_rdata), 16'(exp));
   endtask : rd
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (2) @(posedge core_clk) node <= 1'b1;
         repeat (2) @(posedge core_clk) node <= 1'b0;
      end
      cyc(6);
   endtask : pulses
   // Forced measurement; a second request while pending when dbl is set
   task automatic meas(input logic [7:0] v, input logic dbl);
      int k;
      @(posedge core_clk);
      answer <= v;
      force_measure <= 1'b1;
      @(posedge core_clk);
      force_measure <= 1'b0;
      @(posedge core_clk);
      chk(16'(force_pending), 16'h0001);
      if (dbl) begin
         force_measure <= 1'b1;
         @(posedge core_clk);
         force_measure <= 1'b0;
      end
      k = 0;
      while (force_pending !== 1'b0 && k < 100) begin
         cyc(1);
         k++;
      end
      chk(16'(k < 100), 16'h0001);
      cyc(3);
   endtask : meas
   initial begin
      repeat (40000) @(posedge core_clk);
      err_count++;
      report_and_stop;
   end
   initial begin
      cyc(10);
      reset <= 1'b0;
      wake_above <= 1'b1;
      rd(8'h09, 8'h1D);
      rd(8'h0A, 8'h00);
      rd(8'h0B, 8'h00);
      rd(8'h0C, 8'h00);
      rd(8'h0D, 8'h00);
      $display("end of test: reset values");
      wr(8'h0C, 8'h05);
      cyc(3);
      chk(16'(sleep_active), 16'h0001);
      pulses(4);
      rd(8'h0B, 8'h00);
      wr(8'h0C, 8'h00);
      cyc(3);
      chk(16'(boost_halt), 16'h0001);
      meas(8'h40, 1'b0);
      chk(16'(sleep_active), 16'h0000);
      $display("end of test: count sleep");
      pulses(300);
      rd(8'h0A, 8'h01);
      rd(8'h0B, 8'h2C);
      // A low clock enable freezes synchronisers and counter alike
      clk_en <= 1'b0;
      pulses(5);
      clk_en <= 1'b1;
      rd(8'h0B, 8'h2C);
      chk(16'(count_valid), 16'h0001);
      wake_above <= 1'b0;
      cyc(6);
      chk(16'(count_valid), 16'h0000);
      wake_above <= 1'b1;
      wr(8'h0A, 8'h55);
      rd(8'h0A, 8'h01);
      $display("end of test: pulse count");
      // Host writes the result only while no forced measurement pends
      chk(16'(force_pending), 16'h0000);
      wr(8'h09, 8'h1C);
      cyc(3);
      chk(16'(boost_halt), 16'h0001);
      s0 = starts;
      rd(8'h09, 8'h1C);
      cyc(2);
      chk(16'(starts - s0), 16'h0000);
      chk(16'(force_pending), 16'h0000);
      pulses(10);
      rd(8'h0B, 8'h2C);
      wr(8'h09, 8'h1D);
      cyc(3);
      chk(16'(sleep_active), 16'h0000);
      $display("end of test: low voltage sleep");
      meas(8'h10, 1'b0);
      rd(8'h09, 8'h10);
      chk(16'(sleep_active), 16'h0001);
      lag <= 4'hF;
      s0 = starts;
      meas(8'h50, 1'b1);
      chk(16'(starts - s0), 16'h0001);
      chk(16'(sleep_active), 16'h0000);
      $display("end of test: forced measurement");
      pulses(int'(CMAX));
      rd(8'h0A, CMAX[15:8]);
      rd(8'h0B, CMAX[7:0]);
      wr(8'h0C, 8'h05);
      cyc(3);
      chk(16'(sleep_active), 16'h0000);
      $display("end of test: saturation");
      lag <= 4'h1;
      for (int p = 0; p < 4; p++) begin
         @(posedge core_clk) reset <= 1'b1;
         @(posedge core_clk) reset <= 1'b0;
         measure_period <= 2'(p);
         s0 = starts;
         @(posedge core_clk) measure_time_tick <= 1'b1;
         repeat (512) @(posedge core_clk);
         measure_time_tick <= 1'b0;
         cyc(20);
         chk(16'(starts - s0), 16'(p == 3 ? 0 : 512 >> (6 + p)));
      end
      $display("end of test: measurement period");
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire
